// File: monitor_interrupt_control.v
/*
 * Control and interrupt status logic of a hardware monitor, with an
 * AXI4-Lite register slave.
 * Assumes the measurement datapath drives limit, temperature and
 * diode fault levels synchronous to aclk, and that the overtemp pin
 * wire is resolved outside from its enable.
 */
`timescale 1ns/1ps
`include "monitor_interrupt_control_consts.vh"

module monitor_interrupt_control #(
  parameter [31:0] RST_PULSE_CYC = `RST_PULSE_MS * (`CLK_HZ / 1000)
)
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Monitor condition levels
  input wire [7:0] limit_exceed_one,
  input wire [1:0] temp_alarm,
  input wire [1:0] limit_exceed_two,
  input wire diode_one_fault,
  input wire diode_two_fault,
  input wire chassis_intrusion,
  input wire overtemp_req,
  // Overtemp pin, open drain
  input wire overtemp_pin_n_i,
  output reg overtemp_pin_n_o,
  output reg overtemp_pin_n_oe,
  // Outputs to pins and datapath
  output reg int_n,
  output reg reset_out_n,
  output reg monitor_run,
  output reg defaults_restore
);

  // ==========================================================
  // Declarations
  reg [7:0] ctl_q;
  reg [15:0] st_q;
  reg [15:0] mask_q;
  reg aw_have_q;
  reg w_have_q;
  reg [11:0] aw_addr_q;
  reg [7:0] w_data_q;
  reg w_strb_q;
  reg pulse_busy_q;
  reg [31:0] pulse_cnt_q;
  reg ci_prev_q;
  reg ot_req_prev_q;
  reg [7:0] rd_data_d;
  reg rd_ok_d;
  reg wr_hit_d;
  wire [9:0] wr_idx;
  wire [9:0] rd_idx;
  wire wr_go;
  wire wr_en;
  wire wr_ctl;
  wire wr_init;
  wire ar_take;
  wire rd_clr_one;
  wire rd_clr_two;
  wire [15:0] st_set;
  wire [15:0] st_clr;
  wire [7:0] lim_one;
  wire int_active;
  wire ot_ext;
  wire ot_clr_wr;

  // ==========================================================
  // Address decode
  assign wr_idx = aw_addr_q[11:2];
  assign rd_idx = s_axi_araddr[11:2];
  assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_en = wr_go & w_strb_q;
  assign wr_ctl = wr_en & (wr_idx == {2'b00, `IDX_CONTROL});
  assign wr_init = wr_ctl & w_data_q[`CTL_INIT];
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_clr_one = ar_take & (rd_idx == {2'b00, `IDX_STATUS_ONE});
  assign rd_clr_two = ar_take & (rd_idx == {2'b00, `IDX_STATUS_TWO});

  always @*
  begin
    case (wr_idx)
      {2'b00, `IDX_CONTROL},
      {2'b00, `IDX_STATUS_ONE},
      {2'b00, `IDX_STATUS_TWO},
      {2'b00, `IDX_MASK_ONE},
      {2'b00, `IDX_MASK_TWO},
      {2'b00, `IDX_MON_STATE}:
        wr_hit_d = 1'b1;
      default:
        wr_hit_d = 1'b0;
    endcase
  end

  // ==========================================================
  // AXI4-Lite write channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit_d ? `RESP_OKAY : `RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read data selection
  always @*
  begin
    rd_data_d = 8'h00;
    rd_ok_d = 1'b1;
    case (rd_idx)
      {2'b00, `IDX_CONTROL}:
        rd_data_d = {2'b00, ctl_q[`CTL_SPARE], pulse_busy_q,
                     ctl_q[3:0]};
      {2'b00, `IDX_STATUS_ONE}:
        rd_data_d = st_q[7:0];
      {2'b00, `IDX_STATUS_TWO}:
        rd_data_d = st_q[15:8];
      {2'b00, `IDX_MASK_ONE}:
        rd_data_d = mask_q[7:0];
      {2'b00, `IDX_MASK_TWO}:
        rd_data_d = mask_q[15:8];
      {2'b00, `IDX_MON_STATE}:
        rd_data_d = {4'h0, monitor_run, pulse_busy_q,
                     overtemp_pin_n_oe, ~int_n};
      default:
        rd_ok_d = 1'b0;
    endcase
  end

  // ==========================================================
  // AXI4-Lite read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_data_d};
      s_axi_rresp <= rd_ok_d ? `RESP_OKAY : `RESP_DECERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Control and mask registers
  always @(posedge aclk)
  begin
    if (!aresetn || wr_init)
    begin
      ctl_q <= `RST_CONTROL;
    end
    else if (wr_ctl)
    begin
      ctl_q <= w_data_q & `CTL_STORE_MASK;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn || wr_init)
    begin
      mask_q <= {`RST_MASK, `RST_MASK};
    end
    else if (wr_en && wr_idx == {2'b00, `IDX_MASK_ONE})
    begin
      mask_q[7:0] <= w_data_q;
    end
    else if (wr_en && wr_idx == {2'b00, `IDX_MASK_TWO})
    begin
      mask_q[15:8] <= w_data_q;
    end
  end

  // Run only while started and not held by the interrupt clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      monitor_run <= 1'b0;
      defaults_restore <= 1'b0;
    end
    else
    begin
      monitor_run <= ctl_q[`CTL_START] & ~ctl_q[`CTL_INT_CLR];
      defaults_restore <= wr_init;
    end
  end

  // ==========================================================
  // Reset pulse generator
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulse_busy_q <= 1'b0;
      pulse_cnt_q <= 32'h00000000;
      reset_out_n <= 1'b1;
    end
    else if (wr_ctl && w_data_q[`CTL_RST_PULSE] && !pulse_busy_q)
    begin
      pulse_busy_q <= 1'b1;
      pulse_cnt_q <= RST_PULSE_CYC;
      reset_out_n <= 1'b0;
    end
    else if (pulse_busy_q)
    begin
      if (pulse_cnt_q <= 32'h00000001)
      begin
        pulse_busy_q <= 1'b0;
        pulse_cnt_q <= 32'h00000000;
        reset_out_n <= 1'b1;
      end
      else
      begin
        pulse_cnt_q <= pulse_cnt_q - 32'h00000001;
      end
    end
  end

  // ==========================================================
  // Overtemp output and pin sensing
  assign ot_clr_wr = wr_ctl & w_data_q[`CTL_OT_CLR] & ~wr_init;
  assign ot_ext = ~overtemp_pin_n_i & ~overtemp_pin_n_oe;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overtemp_pin_n_oe <= 1'b0;
      overtemp_pin_n_o <= 1'b0;
      ot_req_prev_q <= 1'b0;
      ci_prev_q <= 1'b0;
    end
    else
    begin
      ot_req_prev_q <= overtemp_req;
      ci_prev_q <= chassis_intrusion;
      overtemp_pin_n_o <= 1'b0;
      if (!ctl_q[`CTL_OT_GATE])
      begin
        overtemp_pin_n_oe <= 1'b0;
      end
      else if (overtemp_req && !ot_req_prev_q)
      begin
        overtemp_pin_n_oe <= 1'b1;
      end
      else if (ot_clr_wr)
      begin
        overtemp_pin_n_oe <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status registers
  assign lim_one = limit_exceed_one | {2'b00, temp_alarm, 4'h0};

  assign st_set[7:0] = lim_one & {8{monitor_run}};
  assign st_set[9:8] = limit_exceed_two & {2{monitor_run}};
  assign st_set[11:10] = 2'b00;
  assign st_set[8 + `ST2_CHASSIS] = chassis_intrusion & ~ci_prev_q;
  assign st_set[8 + `ST2_OT_PIN] = ot_ext;
  assign st_set[8 + `ST2_DIODE_ONE] = diode_one_fault & monitor_run;
  assign st_set[8 + `ST2_DIODE_TWO] = diode_two_fault & monitor_run;

  assign st_clr = {{8{rd_clr_two}}, {8{rd_clr_one}}} | {16{wr_init}};

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_status
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          st_q[gi] <= 1'b0;
        end
        else
        begin
          // A set in the clearing cycle wins
          st_q[gi] <= st_set[gi] | (st_q[gi] & ~st_clr[gi]);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Interrupt output
  assign int_active = |(st_q & ~mask_q);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_n <= 1'b1;
    end
    else
    begin
      // Start bit deliberately not in this term
      int_n <= ~(ctl_q[`CTL_INT_EN] & ~ctl_q[`CTL_INT_CLR]
                 & int_active);
    end
  end

endmodule

// File: monitor_interrupt_control_consts.vh
/*
 * Constants for the monitor interrupt and control block: register
 * indices, control and status bit positions, reset values, timing.
 * Assumes a 125 MHz system clock and word-aligned AXI4-Lite access,
 * byte address = 4 * register index.
 */
`ifndef MONITOR_INTERRUPT_CONTROL_CONSTS_VH
`define MONITOR_INTERRUPT_CONTROL_CONSTS_VH

// ==========================================================
// Register indices
`define IDX_CONTROL 8'h40
`define IDX_STATUS_ONE 8'h41
`define IDX_STATUS_TWO 8'h42
`define IDX_MASK_ONE 8'h43
`define IDX_MASK_TWO 8'h44
`define IDX_MON_STATE 8'h45

// ==========================================================
// Control register bits
`define CTL_START 0
`define CTL_INT_EN 1
`define CTL_OT_GATE 2
`define CTL_INT_CLR 3
`define CTL_RST_PULSE 4
`define CTL_SPARE 5
`define CTL_OT_CLR 6
`define CTL_INIT 7
`define CTL_STORE_MASK 8'h2F

// ==========================================================
// Status two bits
`define ST2_CHASSIS 4
`define ST2_OT_PIN 5
`define ST2_DIODE_ONE 6
`define ST2_DIODE_TWO 7

// ==========================================================
// Reset values
`define RST_CONTROL 8'h00
`define RST_STATUS 8'h00
`define RST_MASK 8'h00

// ==========================================================
// Timing
`define CLK_HZ 125000000
`define RST_PULSE_MS 45

// ==========================================================
// Bus responses
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// File: monitor_interrupt_control_properties.sv
/* Checker for the monitor interrupt control block.
   Assumes the bind below and the top module's ports. */
`timescale 1ns/1ps
module monitor_interrupt_control_properties (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Pins and datapath signals
  input wire overtemp_req,
  input wire overtemp_pin_n_o,
  input wire overtemp_pin_n_oe,
  input wire reset_out_n,
  input wire defaults_restore
);
  // ==========================================
  // Properties
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("late read answer");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready during response");
  pulse_len_a: assert property ($fell(reset_out_n) |=>
    !reset_out_n [*8]) else $error("reset pulse short");
  od_low_a: assert property (overtemp_pin_n_o == 1'b0)
    else $error("overtemp pin drives high");
  ot_cause_a: assert property ($rose(overtemp_pin_n_oe) |->
    $past(overtemp_req)) else $error("overtemp without request");
  restore_one_a: assert property (defaults_restore |=>
    !defaults_restore) else $error("restore pulse long");
endmodule
bind monitor_interrupt_control monitor_interrupt_control_properties
  monitor_interrupt_control_properties_i (.*);

// File: monitor_interrupt_control_tb.sv
/* Self-checking bench for the monitor interrupt control block.
   Assumes the constants header and a 125 MHz clock. */
`timescale 1ns/1ps
`include "monitor_interrupt_control_consts.vh"
module monitor_interrupt_control_tb;
  localparam PULSE = 20;
  reg aclk = 0, aresetn = 0;
  reg [11:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [7:0] lim1 = 0;
  reg [1:0] talarm = 0, lim2 = 0;
  reg d1 = 0, d2 = 0, chassis = 0, ot_req = 0, ext_n = 1;
  wire awready, wready, bvalid, arready, rvalid, ot_o, ot_oe;
  wire int_n, rst_n, run, restore;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire pin_n = ot_oe ? ot_o : ext_n;
  integer failures = 0, check_count = 0, cyc = 0, low_cnt = 0, i;
  reg dr_seen = 0;
  reg [16:0] rnd = 17'd74135;
  reg [7:0] d, e;
  reg [1:0] rs, bs;
  always #4 aclk = ~aclk;
  monitor_interrupt_control #(.RST_PULSE_CYC(PULSE))
    monitor_interrupt_control_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .limit_exceed_one(lim1), .temp_alarm(talarm),
    .limit_exceed_two(lim2), .diode_one_fault(d1),
    .diode_two_fault(d2), .chassis_intrusion(chassis),
    .overtemp_req(ot_req), .overtemp_pin_n_i(pin_n),
    .overtemp_pin_n_o(ot_o), .overtemp_pin_n_oe(ot_oe), .int_n(int_n),
    .reset_out_n(rst_n), .monitor_run(run), .defaults_restore(restore));
  // ==========================================
  // Helpers
  function [16:0] lfsr(input [16:0] s);
    lfsr = {s[15:0], s[16] ^ s[13]};
  endfunction
  // Status one image: limit levels plus temperature alarms at bits 4, 5
  function [7:0] exp_st1(input [16:0] r);
    exp_st1 = r[7:0] | {2'b00, r[9:8], 4'h0};
  endfunction
  task complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk_v(input [7:0] x, input [7:0] y);
    check_count = check_count + 1;
    if (x !== y)
    begin
      failures = failures + 1;
      $display("wrong value byte exp %h got %h", x, y);
    end
  endtask
  task chk_b(input x, input y);
    check_count = check_count + 1;
    if (x !== y)
    begin
      failures = failures + 1;
      $display("wrong value flag exp %b got %b", x, y);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input [7:0] idx, input [7:0] v);
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    // Mask two writes hold bready back so the response must wait
    bready <= (idx != `IDX_MASK_TWO);
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid && !bready) bready <= 1;
    end
    while (!(bvalid === 1'b1 && bready === 1'b1));
    bs = bresp;
    bready <= 0;
  endtask
  task rd(input [7:0] idx);
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1;
    // Control reads hold rready back so the read data must wait
    rready <= (idx != `IDX_CONTROL);
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid && !rready) rready <= 1;
    end
    while (!(rvalid === 1'b1 && rready === 1'b1));
    d = rdata[7:0];
    rs = rresp;
    rready <= 0;
  endtask
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (!rst_n) low_cnt = low_cnt + 1;
    if (restore) dr_seen = 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      complete_run;
    end
  end
  // ==========================================
  // Scenarios
  initial
  begin
    tick(10);
    aresetn <= 1;
    rd(`IDX_STATUS_ONE); chk_v(8'h00, d);
    rd(`IDX_STATUS_TWO); chk_v(8'h00, d);
    rd(`IDX_CONTROL); chk_v(8'h00, d);
    chk_b(1'b1, int_n);
    chk_b(1'b0, run);
    rd(8'h50); chk_v(8'h03, {6'h0, rs});
    wr(8'h50, 8'hFF); chk_v(8'h03, {6'h0, bs});
    wr(`IDX_CONTROL, 8'h03); tick(3); chk_b(1'b1, run);
    chk_v(8'h00, {6'h0, bs});
    for (i = 0; i < 6; i = i + 1)
    begin
      rnd = lfsr(rnd);
      wr(`IDX_MASK_ONE, rnd[15:8]);
      lim1 <= rnd[7:0];
      talarm <= rnd[9:8];
      tick(3);
      e = exp_st1(rnd);
      chk_b(~|(e & ~rnd[15:8]), int_n);
      lim1 <= 0;
      talarm <= 0;
      tick(2);
      rd(`IDX_STATUS_ONE); chk_v(e, d);
      rd(`IDX_STATUS_ONE); chk_v(8'h00, d);
    end
    wr(`IDX_MASK_ONE, 8'h00);
    lim1 <= 8'h81; tick(3);
    rd(`IDX_STATUS_ONE); chk_v(8'h81, d);
    tick(2);
    rd(`IDX_STATUS_ONE); chk_v(8'h81, d);
    wr(`IDX_CONTROL, 8'h01); tick(2); chk_b(1'b1, int_n);
    wr(`IDX_CONTROL, 8'h02); tick(2); chk_b(1'b0, int_n);
    lim1 <= 0;
    wr(`IDX_CONTROL, 8'h0B); tick(2); chk_b(1'b1, int_n);
    chk_b(1'b0, run);
    lim1 <= 8'h04; tick(3); lim1 <= 0;
    rd(`IDX_STATUS_ONE); chk_v(8'h81, d);
    wr(`IDX_CONTROL, 8'h03); tick(3); chk_b(1'b1, run);
    lim2 <= 2'b11; d1 <= 1; d2 <= 1; chassis <= 1; ext_n <= 0;
    tick(3);
    lim2 <= 0; d1 <= 0; d2 <= 0; chassis <= 0; ext_n <= 1;
    tick(2);
    rd(`IDX_STATUS_TWO); chk_v(8'hF3, d & 8'hF3);
    ot_req <= 1; tick(3); chk_b(1'b0, ot_oe);
    ot_req <= 0; wr(`IDX_CONTROL, 8'h07);
    ot_req <= 1; tick(3); chk_b(1'b1, ot_oe);
    rd(`IDX_MON_STATE); chk_v(8'h0A, d);
    rd(`IDX_STATUS_TWO); chk_v(8'h00, d & 8'hF3);
    wr(`IDX_CONTROL, 8'h47); tick(2); chk_b(1'b0, ot_oe);
    ot_req <= 0;
    rd(`IDX_CONTROL); chk_v(8'h07, d);
    low_cnt = 0;
    wr(`IDX_CONTROL, 8'h13); tick(40); chk_v(PULSE, low_cnt);
    rd(`IDX_CONTROL); chk_v(8'h03, d);
    wr(`IDX_MASK_TWO, 8'h5A);
    chk_v(8'h00, {6'h0, bs});
    lim1 <= 8'h08; tick(3); lim1 <= 0; tick(2);
    dr_seen = 0;
    wr(`IDX_CONTROL, 8'h80); tick(2); chk_b(1'b1, dr_seen);
    rd(`IDX_CONTROL); chk_v(8'h00, d);
    rd(`IDX_MASK_TWO); chk_v(8'h00, d);
    rd(`IDX_STATUS_ONE); chk_v(8'h00, d);
    chk_b(1'b0, run);
    complete_run;
  end
endmodule
